// ### design/spiev_top.sv
// status flags and interrupt event gating of a serial peripheral port
// assumes event inputs come from port logic on mclk_i; the link clock is a foreign pin
`timescale 1ns/100ps
module spiev_top
  import spiev_pkg::*;
#(
  parameter int CNT_W = SPIEV_CNT_W,
  parameter int DEPTH = SPIEV_DEPTH
) (
  input wire logic mclk_i,
  input wire logic arst_n_i,
  input wire logic [3:0] addr_i,
  input wire logic [15:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [15:0] rdata_o,
  input wire logic sck_i,
  input wire logic frame_err_i,
  input wire logic underrun_i,
  input wire logic tx_sr_full_i,
  input wire logic rx_done_i,
  input wire logic tx_load_i,
  input wire logic buf_read_i,
  input wire logic buf_write_i,
  input wire logic [CNT_W-1:0] rx_elm_i,
  input wire logic [CNT_W-1:0] tx_elm_i,
  output logic port_enable_o,
  output logic ignore_underrun_o,
  output logic enhanced_o,
  output logic irq_o
);

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    logic [15:0] rdata;
    logic frm;
    logic tur;
    logic rov;
    logic rbe;
    logic tbe;
    logic rbf;
    logic tbf;
    logic [15:0] mask;
    logic [2:0] ctrl;
    logic [2:0] sck_sync;
    logic [3:0] idle_cnt;
    logic irq;
  } spiev_state_t;

  spiev_state_t s_q;
  spiev_state_t s_d;
  logic [15:0] stat;
  logic busy;
  logic shift_reg_empty_flag;
  logic [15:0] events;

  localparam spiev_state_t S_RST = '{
    rdata: 16'h0000, frm: 1'b0, tur: 1'b0, rov: 1'b0, rbe: 1'b1, tbe: 1'b1, rbf: 1'b0, tbf: 1'b0,
    mask: SPIEV_MASK_RST, ctrl: SPIEV_CTRL_RST, sck_sync: 3'h0, idle_cnt: 4'h0, irq: 1'b0};

  function automatic logic is_zero(input logic [CNT_W-1:0] v);
    return v == '0;
  endfunction

  // ****************************************
  // status view
  // ****************************************
  always_comb begin
    busy = (s_q.idle_cnt != 4'h0) | tx_sr_full_i | ~shift_reg_empty_flag_raw();
    shift_reg_empty_flag = ~tx_sr_full_i & (s_q.ctrl[SPIEV_C_ENH] ? is_zero(tx_elm_i) : s_q.tbe);
    stat = 16'h0000;
    stat[SPIEV_B_FRAME_ERROR_FLAG] = s_q.frm;
    stat[SPIEV_B_BUSY] = busy;
    stat[SPIEV_B_TUR] = s_q.tur;
    stat[SPIEV_B_SHIFT_REG_EMPTY_FLAG] = shift_reg_empty_flag;
    stat[SPIEV_B_ROV] = s_q.rov;
    stat[SPIEV_B_RBE] = s_q.ctrl[SPIEV_C_ENH] ? is_zero(rx_elm_i) : s_q.rbe;
    stat[SPIEV_B_TBE] = s_q.ctrl[SPIEV_C_ENH] ? is_zero(tx_elm_i) : s_q.tbe;
    stat[SPIEV_B_TBF] = s_q.ctrl[SPIEV_C_ENH] ? (tx_elm_i == CNT_W'(DEPTH-1)) : s_q.tbf;
    stat[SPIEV_B_RBF] = s_q.ctrl[SPIEV_C_ENH] ? (rx_elm_i == CNT_W'(DEPTH-1)) : s_q.rbf;
    stat = stat & SPIEV_STAT_IMPL;
    events = stat & s_q.mask;
  end

  function automatic logic shift_reg_empty_flag_raw();
    return s_q.ctrl[SPIEV_C_ENH] ? is_zero(tx_elm_i) : s_q.tbe;
  endfunction

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    logic clr_wr;
    logic rx_full_now;
    clr_wr = wr_i & (addr_i == SPIEV_ADDR_STAT);
    rx_full_now = s_q.ctrl[SPIEV_C_ENH] ? (rx_elm_i == CNT_W'(DEPTH-1)) : s_q.rbf;
    s_d = s_q;
    s_d.sck_sync = {s_q.sck_sync[1:0], sck_i};
    // activity holds for a few cycles after the last link clock edge
    if (s_q.sck_sync[2] != s_q.sck_sync[1]) begin
      s_d.idle_cnt = 4'hF;
    end else if (s_q.idle_cnt != 4'h0) begin
      s_d.idle_cnt = s_q.idle_cnt - 4'h1;
    end
    // frm and rov: a write of zero clears, a new event wins; tur ignores writes; cleared while port off, tracks underrun_i if ignore-underrun
    if (clr_wr && !wdata_i[SPIEV_B_FRAME_ERROR_FLAG]) begin
      s_d.frm = 1'b0;
    end
    if (frame_err_i) begin
      s_d.frm = 1'b1;
    end
    if (clr_wr && !wdata_i[SPIEV_B_ROV]) begin
      s_d.rov = 1'b0;
    end
    if (rx_done_i && rx_full_now) begin
      s_d.rov = 1'b1;
    end
    if (s_q.ctrl[SPIEV_C_IGNORE_UNDERRUN]) begin
      s_d.tur = underrun_i;
    end else if (underrun_i) begin
      s_d.tur = 1'b1;
    end
    if (!s_q.ctrl[SPIEV_C_EN]) begin
      s_d.tur = 1'b0;
    end
    // standard buffer tracking
    if (buf_read_i) begin
      s_d.rbe = 1'b1;
      s_d.rbf = 1'b0;
    end
    if (rx_done_i && !rx_full_now) begin
      s_d.rbe = 1'b0;
      s_d.rbf = 1'b1;
    end
    if (tx_load_i) begin
      s_d.tbe = 1'b1;
      s_d.tbf = 1'b0;
    end
    if (buf_write_i) begin
      s_d.tbe = 1'b0;
      s_d.tbf = 1'b1;
    end
    if (wr_i && addr_i == SPIEV_ADDR_MASK) begin
      s_d.mask = wdata_i & SPIEV_STAT_IMPL;
    end
    if (wr_i && addr_i == SPIEV_ADDR_CTRL) begin
      s_d.ctrl = wdata_i[2:0];
    end
    s_d.rdata = 16'h0000;
    if (rd_i) begin
      case (addr_i)
        SPIEV_ADDR_STAT: s_d.rdata = stat;
        SPIEV_ADDR_MASK: s_d.rdata = s_q.mask;
        SPIEV_ADDR_CTRL: s_d.rdata = {13'h0000, s_q.ctrl};
        SPIEV_ADDR_CNT: s_d.rdata = {{(8-CNT_W){1'b0}}, tx_elm_i, {(8-CNT_W){1'b0}}, rx_elm_i};
        default: s_d.rdata = 16'h0000;
      endcase
    end
    s_d.irq = |events;
  end

  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      s_q <= S_RST;
    end else begin
      s_q <= s_d;
    end
  end

  assign rdata_o = s_q.rdata;
  assign port_enable_o = s_q.ctrl[SPIEV_C_EN];
  assign ignore_underrun_o = s_q.ctrl[SPIEV_C_IGNORE_UNDERRUN];
  assign enhanced_o = s_q.ctrl[SPIEV_C_ENH];
  assign irq_o = s_q.irq;

endmodule // spiev_top

// ### design/spiev_pkg.sv
// package of the serial-port status and event block: offsets, bit positions, reset values, carriers
// assumes one 16-bit register port on the system clock
package spiev_pkg;

  // ****************************************
  // register map
  // ****************************************
  localparam logic [3:0] SPIEV_ADDR_STAT = 4'h0;
  localparam logic [3:0] SPIEV_ADDR_MASK = 4'h1;
  localparam logic [3:0] SPIEV_ADDR_CTRL = 4'h2;
  localparam logic [3:0] SPIEV_ADDR_CNT = 4'h3;

  // ****************************************
  // status and mask bit positions
  // ****************************************
  localparam int SPIEV_B_FRAME_ERROR_FLAG = 12;
  localparam int SPIEV_B_BUSY = 11;
  localparam int SPIEV_B_TUR = 8;
  localparam int SPIEV_B_SHIFT_REG_EMPTY_FLAG = 7;
  localparam int SPIEV_B_ROV = 6;
  localparam int SPIEV_B_RBE = 5;
  localparam int SPIEV_B_TBE = 3;
  localparam int SPIEV_B_TBF = 1;
  localparam int SPIEV_B_RBF = 0;
  localparam logic [15:0] SPIEV_STAT_IMPL = 16'h19EB;
  localparam logic [15:0] SPIEV_STAT_RST = 16'h00A8;
  localparam logic [15:0] SPIEV_MASK_RST = 16'h0000;

  // ****************************************
  // control register bits
  // ****************************************
  localparam int SPIEV_C_EN = 0;
  localparam int SPIEV_C_IGNORE_UNDERRUN = 1;
  localparam int SPIEV_C_ENH = 2;
  localparam logic [2:0] SPIEV_CTRL_RST = 3'h0;

  localparam int SPIEV_CNT_W = 6;
  localparam int SPIEV_DEPTH = 32;

  typedef struct packed {
    logic [3:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } spiev_bus_t;

  // raw events from the port datapath
  typedef struct packed {
    logic frame_err;
    logic busy;
    logic underrun;
    logic tx_sr_full;
    logic rx_done;
    logic tx_load;
    logic buf_read;
    logic buf_write;
    logic [SPIEV_CNT_W-1:0] rx_elm;
    logic [SPIEV_CNT_W-1:0] tx_elm;
  } spiev_evt_t;

endpackage

// ### dv/spiev_chk.sv
// port assertions of spiev_top
// assumes one reset domain on mclk_i
`timescale 1ns/100ps
module spiev_chk
  import spiev_pkg::*;
#(parameter int CNT_W = SPIEV_CNT_W) (
  input wire logic mclk_i,
  input wire logic arst_n_i,
  input wire logic [3:0] addr_i,
  input wire logic [15:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [15:0] rdata_o,
  input wire logic frame_err_i,
  input wire logic tx_sr_full_i,
  input wire logic [CNT_W-1:0] rx_elm_i,
  input wire logic [CNT_W-1:0] tx_elm_i,
  input wire logic port_enable_o,
  input wire logic enhanced_o,
  input wire logic irq_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!arst_n_i);
  wire logic rs = rd_i && addr_i == SPIEV_ADDR_STAT;
  AST_STAT_SPARE: assert property (rs |=> (rdata_o & ~SPIEV_STAT_IMPL) == 16'h0000) else $error("status spare");
  AST_MASK_SPARE: assert property (rd_i && addr_i == SPIEV_ADDR_MASK |=> (rdata_o & ~SPIEV_STAT_IMPL) == 16'h0000)
    else $error("mask spare");
  AST_FRM_SET: assert property (frame_err_i ##1 !wr_i ##1 rs |=> rdata_o[12]) else $error("frame error lost");
  AST_TUR_OFF: assert property (!port_enable_o && !$past(port_enable_o) && rs |=> !rdata_o[8])
    else $error("underrun while off");
  AST_SHIFT_REG_EMPTY_FLAG: assert property (tx_sr_full_i && $past(tx_sr_full_i) && rs |=> !rdata_o[7]) else $error("shift empty");
  AST_ENH_RX: assert property (enhanced_o && $past(enhanced_o) && $stable(rx_elm_i) && rs
    |=> rdata_o[5] == ($past(rx_elm_i) == 0)) else $error("rx empty");
  AST_ENH_TX: assert property (enhanced_o && $past(enhanced_o) && $stable(tx_elm_i) && rs
    |=> rdata_o[3] == ($past(tx_elm_i) == 0)) else $error("tx empty");
  AST_IRQ_OFF: assert property (wr_i && addr_i == SPIEV_ADDR_MASK && wdata_i == 16'h0000 |=> ##1 !irq_o)
    else $error("irq with empty mask");
endmodule // spiev_chk
bind spiev_top spiev_chk #(.CNT_W(CNT_W)) u_chk (.*);

// ### dv/spiev_peer.sv
// far serial peripheral: link clock only inside frames, idle low
`timescale 1ns/100ps
module spiev_peer (
  input wire logic frame_i,
  output logic sck_o
);
  initial begin
    sck_o = 1'b0;
    #7;
    forever begin
      #80;
      sck_o = frame_i ? ~sck_o : 1'b0;
    end
  end
endmodule // spiev_peer

// ### dv/test_spi_status_and_irq_events.sv
// register-call bench of the status and event block
// assumes spiev_top, spiev_peer and the bound checker
`timescale 1ns/100ps
module test_spi_status_and_irq_events
  import spiev_pkg::*;
;
  localparam logic [3:0] ST = SPIEV_ADDR_STAT;
  localparam logic [3:0] MK = SPIEV_ADDR_MASK;
  localparam logic [19:0] FE = 20'h8_0000, RX = 20'h0_8000, TL = 20'h0_4000, BR = 20'h0_2000, BW = 20'h0_1000;
  localparam logic [19:0] UR = 20'h2_0000;
  logic mclk_i = 1'b0, arst_n_i = 1'b0, wr = 1'b0, rd = 1'b0, go = 1'b0, irq, sck;
  logic pe, iu, eh;
  logic [3:0] addr = 4'h0;
  logic [15:0] wdata = 16'h0000, rdata;
  spiev_evt_t ev = '0;
  int miscompares = 0, samples_checked = 0;
  int bl[9] = '{12, 11, 8, 7, 6, 5, 3, 1, 0};
  always #5 mclk_i = ~mclk_i;
  spiev_peer peer (.frame_i(go), .sck_o(sck));
  spiev_top #(.DEPTH(4)) dut (.mclk_i(mclk_i), .arst_n_i(arst_n_i), .addr_i(addr), .wdata_i(wdata), .wr_i(wr),
    .rd_i(rd), .rdata_o(rdata), .sck_i(sck), .frame_err_i(ev.frame_err), .underrun_i(ev.underrun),
    .tx_sr_full_i(ev.tx_sr_full), .rx_done_i(ev.rx_done), .tx_load_i(ev.tx_load), .buf_read_i(ev.buf_read),
    .buf_write_i(ev.buf_write), .rx_elm_i(ev.rx_elm), .tx_elm_i(ev.tx_elm), .port_enable_o(pe),
    .ignore_underrun_o(iu), .enhanced_o(eh), .irq_o(irq));
  task automatic cmp(input logic [15:0] g, input logic [15:0] e);
    samples_checked++;
    if (g !== e) begin
      miscompares++;
      $display("MISMATCH t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic bw(input logic [3:0] a, input logic [15:0] d);
    @(posedge mclk_i);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge mclk_i);
    wr <= 1'b0;
  endtask
  task automatic br(input logic [3:0] a, input logic [15:0] m, input logic [15:0] e);
    @(posedge mclk_i);
    addr <= a;
    rd <= 1'b1;
    @(posedge mclk_i);
    rd <= 1'b0;
    #1;
    cmp(rdata & m, e);
  endtask
  task automatic pls(input logic [19:0] p);
    @(posedge mclk_i);
    ev <= ev | p;
    @(posedge mclk_i);
    ev <= ev & ~p;
  endtask
  task automatic irq_is(input logic e);
    repeat (2) @(posedge mclk_i);
    #1;
    cmp(16'(irq), 16'(e));
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge mclk_i);
    arst_n_i <= 1'b1;
    br(ST, 16'hFFFF, 16'h00A8);
    br(MK, 16'hFFFF, 16'h0000);
    br(4'hF, 16'hFFFF, 16'h0000);
    foreach (bl[i]) begin
      bw(MK, 16'h0001 << bl[i]);
      irq_is(bl[i] inside {7, 5, 3});
    end
    bw(MK, 16'h1000);
    pls(FE);
    br(ST, 16'hFFFF, 16'h10A8);
    irq_is(1'b1);
    bw(ST, 16'hEFFF);
    br(ST, 16'hFFFF, 16'h00A8);
    bw(SPIEV_ADDR_CTRL, 16'h0001);
    pls(UR);
    br(ST, 16'h0100, 16'h0100);
    bw(MK, 16'h0100);
    irq_is(1'b1);
    bw(MK, 16'h0000);
    bw(SPIEV_ADDR_CTRL, 16'h0000);
    br(ST, 16'h0100, 16'h0000);
    bw(SPIEV_ADDR_CTRL, 16'h0003);
    br(SPIEV_ADDR_CTRL, 16'hFFFF, 16'h0003);
    cmp({13'h0000, eh, iu, pe}, 16'h0003);
    ev.underrun <= 1'b1;
    br(ST, 16'h0100, 16'h0100);
    ev.underrun <= 1'b0;
    br(ST, 16'h0100, 16'h0000);
    pls(RX);
    br(ST, 16'h0061, 16'h0001);
    pls(RX);
    br(ST, 16'h0061, 16'h0041);
    bw(MK, 16'h0040);
    irq_is(1'b1);
    bw(MK, 16'h0000);
    pls(BR);
    br(ST, 16'h0061, 16'h0060);
    bw(ST, 16'hFFBF);
    br(ST, 16'h0061, 16'h0020);
    pls(BW);
    br(ST, 16'h088A, 16'h0802);
    ev.tx_sr_full <= 1'b1;
    pls(TL);
    br(ST, 16'h008A, 16'h0008);
    ev.tx_sr_full <= 1'b0;
    br(ST, 16'h008A, 16'h0088);
    go <= 1'b1;
    repeat (40) @(posedge mclk_i);
    br(ST, 16'h0800, 16'h0800);
    bw(MK, 16'h0800);
    irq_is(1'b1);
    bw(MK, 16'h0000);
    go <= 1'b0;
    repeat (40) @(posedge mclk_i);
    br(ST, 16'h0800, 16'h0000);
    ev.rx_elm <= 6'h03;
    bw(SPIEV_ADDR_CTRL, 16'h0004);
    br(ST, 16'h0029, 16'h0009);
    bw(MK, 16'h0001);
    irq_is(1'b1);
    ev.rx_elm <= 6'h00;
    ev.tx_elm <= 6'h03;
    br(ST, 16'h002B, 16'h0022);
    br(SPIEV_ADDR_CNT, 16'hFFFF, 16'h0300);
    bw(MK, 16'h0002);
    irq_is(1'b1);
    bw(MK, 16'h0000);
    irq_is(1'b0);
    give_verdict();
  end
  initial begin
    #50000;
    miscompares++;
    give_verdict();
  end
endmodule // test_spi_status_and_irq_events
